// ==== bench/lcpb_led_model.sv ====
/*
  LED strings on the six sinks: wiring as the bench asks, presence senses.
  Assumes the bench changes wiring only around a reset of the router.
*/
`timescale 1ns/10ps
module lcpb_led_model
  import lcpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Wiring asked for
  input wire logic [5:0] want_present,
  input wire logic [1:0] want_gang,
  // Router side
  input wire logic [lcpb_pkg::NCH-1:0] led_pwm_r,
  output logic [lcpb_pkg::NCH-1:0] string_present,
  output logic [1:0] gang_sense,
  output logic [lcpb_pkg::NCH-1:0] lit
);
  // Rewire only while powered down, so detection never sees a change
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      string_present <= want_present;
      gang_sense <= want_gang;
    end
  end
  // A string lights only where wired and driven
  assign lit = led_pwm_r & string_present;
endmodule : lcpb_led_model

// ==== bench/lcpb_monitor.sv ====
/*
  Checker for the router top: concurrent assertions on its ports only.
  Assumes one clock domain; bound to every lcpb_router at the foot.
*/
`timescale 1ns/10ps
module lcpb_monitor
  import lcpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic [3:0] reg_idx,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_r,
  // Outputs watched
  input wire logic [lcpb_pkg::NCH-1:0] led_pwm_r,
  input wire logic [lcpb_pkg::NCH*lcpb_pkg::CUR_W-1:0] led_current_r,
  input wire logic [lcpb_pkg::NCH-1:0] boost_loop_en_r,
  input wire logic sloper_en_r,
  input wire logic hybrid_en_r,
  input wire logic [2:0] string_config_detected_r,
  input wire logic detect_done_r
);
  logic loaded_r;
  logic [5:0] mask_r;
  logic [9:0] age_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Shadows of load and mask writes; age saturates so it never wraps
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loaded_r <= 1'b0;
      mask_r <= 6'h00;
      age_r <= 10'h000;
    end else begin
      if (reg_wr && reg_idx == REG_LOAD) loaded_r <= 1'b1;
      if (reg_wr && reg_idx == REG_EXT_SUPPLY) mask_r <= reg_wdata[5:0];
      if (age_r != 10'h3FF) age_r <= age_r + 10'h001;
    end
  end

  rst_ctrl_a: assert property ($rose(rstn) |-> sloper_en_r && !hybrid_en_r)
    else $error("control bits wrong after reset");
  rst_cur_a: assert property ($rose(rstn) |=> led_current_r == {6{CUR_RST}})
    else $error("current codes not full scale after reset");
  cur_hold_a: assert property ($changed(led_current_r) && $past(rstn, 2) |-> loaded_r)
    else $error("current changed without a load trigger");
  ctrl_bits_a: assert property (reg_wr && reg_idx == REG_DISP_CTRL |=>
    sloper_en_r == $past(reg_wdata[1]) && hybrid_en_r == $past(reg_wdata[2]))
    else $error("display control bits differ from write");
  mask_out_a: assert property (mask_r == $past(mask_r, 2) |-> !(|(boost_loop_en_r & mask_r)))
    else $error("masked channel still in boost loop");
  done_time_a: assert property ($rose(detect_done_r) |-> age_r >= 10'h191 && age_r <= 10'h195)
    else $error("detection finished at wrong time");
  done_hold_a: assert property (detect_done_r |=> detect_done_r && $stable(string_config_detected_r))
    else $error("detected configuration changed");
  conf_read_a: assert property (reg_idx == REG_STRING_CONF && detect_done_r |=>
    reg_rdata_r == {13'h0000, string_config_detected_r})
    else $error("configuration read differs");
  unmapped_a: assert property (reg_idx > 4'h7 |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  dark_a: assert property (!detect_done_r |-> led_pwm_r == 6'h00)
    else $error("channel lit before detection");

  // Main scenarios reached
  cover property ($rose(detect_done_r));
  cover property ($changed(led_current_r) && loaded_r);
  cover property ($rose(led_pwm_r[0]));
endmodule : lcpb_monitor

bind lcpb_router lcpb_monitor u_mon (.clk_sys, .rstn, .reg_wr, .reg_idx, .reg_wdata,
  .reg_rdata_r, .led_pwm_r, .led_current_r, .boost_loop_en_r, .sloper_en_r,
  .hybrid_en_r, .string_config_detected_r, .detect_done_r);

// ==== bench/led_channel_pwm_brightness_router_tb_top.sv ====
/*
  Bench for the router: register tasks, wiring table, current latch,
  routing, duty, phase and input select checks.
  Assumes frequency code 7, a period of 1024 ticks, until a last run at code 6.
*/
`timescale 1ns/10ps
module led_channel_pwm_brightness_router_tb_top;
  import lcpb_pkg::*;
  localparam int PER = OSC_HZ / FREQ_HZ[7];
  localparam int PCLK = PER * TICK_DIV;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic [3:0] reg_idx = 4'h0;
  logic [2:0] reg_ch = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic pwm_in = 1'b0;
  logic [2:0] fsel = 3'h7;
  logic [5:0] want_present = 6'h3F;
  logic [1:0] want_gang = 2'h0;
  logic [15:0] reg_rdata_r, rd;
  logic [5:0] string_present, led_pwm_r, boost_loop_en_r, lit;
  logic [71:0] led_current_r;
  logic [1:0] gang_sense;
  logic [2:0] string_config_detected_r;
  logic sloper_en_r, hybrid_en_r, detect_done_r;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int k, cnt, hi;
  // Wiring table: presence, ganging, expected code
  logic [5:0] tp [9] = '{6'h3F, 6'h1F, 6'h0F, 6'h07, 6'h03, 6'h3F, 6'h3F, 6'h3F, 6'h2A};
  logic [1:0] tg [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  logic [2:0] tc [9] = '{CONF_SIX, CONF_FIVE, CONF_FOUR, CONF_THREE, CONF_TWO,
    CONF_GANG3, CONF_GANG2, CONF_GANG1, CONF_SIX};

  lcpb_router dut (.clk_sys, .rstn, .reg_wr, .reg_idx, .reg_ch, .reg_wdata,
    .reg_rdata_r, .pwm_frequency_resistor(fsel), .string_present, .gang_sense,
    .pwm_in, .led_pwm_r, .led_current_r, .boost_loop_en_r, .sloper_en_r,
    .hybrid_en_r, .string_config_detected_r, .detect_done_r);
  lcpb_led_model u_led (.clk_sys, .rstn, .want_present, .want_gang, .led_pwm_r,
    .string_present, .gang_sense, .lit);

  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Hang guard; the run needs about 54000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count = err_count + 1;
      end_sim();
    end
  end

  task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_val

  task automatic chk_cnt(input int e, input int g);
    n_tests = n_tests + 1;
    if (g != e) begin
      err_count = err_count + 1;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_cnt

  // High clocks of one pulse for a 16-bit brightness
  function automatic int hi_of(input int b);
    return (b * PER / 65536) * TICK_DIV;
  endfunction : hi_of

  task automatic wr(input logic [3:0] i, input logic [2:0] c, input logic [15:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_idx = i;
    reg_ch = c;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken one clock later
  task automatic rd_reg(input logic [3:0] i, input logic [2:0] c);
    @(negedge clk_sys);
    reg_idx = i;
    reg_ch = c;
    @(negedge clk_sys);
    rd = reg_rdata_r;
  endtask : rd_reg

  task automatic do_reset(input logic [5:0] p, input logic [1:0] g);
    rstn = 1'b0;
    want_present = p;
    want_gang = g;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    for (k = 0; k < 600 && detect_done_r !== 1'b1; k++) @(negedge clk_sys);
  endtask : do_reset

  // Count clocks until a channel shows a level, bounded by two periods
  task automatic wait_lvl(input int ch, input logic lvl);
    for (k = 0; k < 2 * PCLK && led_pwm_r[ch] !== lvl; k++) begin
      cnt++;
      @(negedge clk_sys);
    end
  endtask : wait_lvl

  // Leaves hi as pulse length and cnt as period, ending at a rise
  task automatic meas(input int ch);
    wait_lvl(ch, 1'b0);
    wait_lvl(ch, 1'b1);
    cnt = 0;
    wait_lvl(ch, 1'b0);
    hi = cnt;
    wait_lvl(ch, 1'b1);
  endtask : meas

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    for (int r = 0; r < 9; r++) begin
      do_reset(tp[r], tg[r]);
      chk_val({13'h0000, tc[r]}, {13'h0000, string_config_detected_r});
      rd_reg(REG_STRING_CONF, 3'h0);
      chk_val({13'h0000, tc[r]}, rd);
    end
    do_reset(6'h3F, 2'h0);
    chk_val(16'h0001, {15'h0000, sloper_en_r});
    chk_val(16'h0000, {15'h0000, hybrid_en_r});
    chk_val(16'h003F, {10'h000, boost_loop_en_r});
    chk_val({4'h0, CUR_RST}, {4'h0, led_current_r[11:0]});
    for (int c = 0; c < 6; c++) begin
      rd_reg(REG_SRC, c[2:0]);
      chk_val({13'h0000, SRC_RST}, rd);
    end
    rd_reg(REG_EXT_SUPPLY, 3'h0);
    chk_val(16'h0000, rd);
    wr(REG_EXT_SUPPLY, 3'h0, 16'h0030);
    rd_reg(REG_EXT_SUPPLY, 3'h0);
    chk_val(16'h0030, rd);
    chk_val(16'h000F, {10'h000, boost_loop_en_r});
    // Staged current must wait for the trigger, then a period boundary
    wr(REG_CUR, 3'h2, 16'h0800);
    repeat (PCLK + 100) @(negedge clk_sys);
    chk_val({4'h0, CUR_RST}, {4'h0, led_current_r[35:24]});
    wr(REG_LOAD, 3'h0, 16'h0000);
    for (k = 0; k < PCLK + 8 && led_current_r[35:24] !== 12'h800; k++) @(negedge clk_sys);
    chk_val(16'h0800, {4'h0, led_current_r[35:24]});
    chk_val({4'h0, CUR_RST}, {4'h0, led_current_r[11:0]});
    wr(REG_DISP_CTRL, 3'h0, 16'h0004);
    chk_val(16'h0002, {14'h0000, hybrid_en_r, sloper_en_r});
    wr(REG_DISPLAY_BRIGHTNESS_VALUE, 3'h0, 16'h8000);
    meas(0);
    meas(0);
    chk_cnt(hi_of(32'h8000), hi);
    chk_cnt(PCLK, cnt);
    // From a rise of channel 0 to the next rise of channel 1
    cnt = 0;
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    chk_cnt((PER - PER / 6) * TICK_DIV, cnt);
    wr(REG_SRC, 3'h4, 16'h0004);
    wr(REG_SRC, 3'h5, 16'h0005);
    wr(REG_CLUSTER, 3'h4, 16'h4000);
    wr(REG_CLUSTER, 3'h5, 16'hC000);
    wr(REG_LOAD, 3'h0, 16'h0000);
    rd_reg(REG_SRC, 3'h5);
    chk_val(16'h0005, rd);
    meas(4);
    meas(4);
    chk_cnt(hi_of(32'h4000), hi);
    meas(5);
    meas(5);
    chk_cnt(hi_of(32'hC000), hi);
    wr(REG_STRING_CONF, 3'h0, 16'h0007);
    rd_reg(REG_STRING_CONF, 3'h0);
    chk_val({13'h0000, CONF_SIX}, rd);
    rd_reg(4'h9, 3'h0);
    chk_val(16'h0000, rd);
    // Pin input held low: channel 0 goes dark once the pin path is chosen
    wr(REG_DISP_CTRL, 3'h0, 16'h0005);
    repeat (2 * PCLK) @(negedge clk_sys);
    cnt = 0;
    for (k = 0; k < PCLK; k++) begin
      if (lit[0] !== 1'b0) cnt++;
      @(negedge clk_sys);
    end
    chk_cnt(0, cnt);
    // A second frequency code after a fresh power-up
    fsel = 3'h6;
    do_reset(6'h3F, 2'h0);
    wr(REG_DISPLAY_BRIGHTNESS_VALUE, 3'h0, 16'h8000);
    meas(0);
    meas(0);
    chk_cnt((OSC_HZ / FREQ_HZ[6]) * TICK_DIV, cnt);
    end_sim();
  end
endmodule : led_channel_pwm_brightness_router_tb_top

// ==== rtl/lcpb_chan.sv ====
/*
  One LED channel PWM generator on the 20 MHz tick: a period counter started
  at the channel's phase offset, duty and current taken at period boundaries.
  Assumes period, brightness and current inputs are held by the parent.
*/
`timescale 1ns/10ps
module lcpb_chan
  import lcpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Timebase and phase
  input wire logic tick,
  input wire logic start,
  input wire logic enable,
  input wire logic [lcpb_pkg::PER_W-1:0] period,
  input wire logic [2:0] slot,
  input wire logic [2:0] nphase,
  // Values to apply at the boundary
  input wire logic [lcpb_pkg::BRT_W-1:0] brt,
  input wire logic [lcpb_pkg::CUR_W-1:0] cur,
  // Outputs
  output logic pwm_r,
  output logic [lcpb_pkg::CUR_W-1:0] cur_act_r
);
  import lcpb_pkg::*;

  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] duty_r;
  logic [PER_W-1:0] offset;
  logic [PER_W+5:0] share;
  logic [PER_W+BRT_W-1:0] prod;
  logic wrap;

  // Offset is slot/nphase of the period
  always_comb begin
    share = (PER_W+6)'(period) * (PER_W+6)'(slot);
    case (nphase)
      3'd2: offset = PER_W'(share / 2);
      3'd3: offset = PER_W'(share / 3);
      3'd4: offset = PER_W'(share / 4);
      3'd5: offset = PER_W'(share / 5);
      3'd6: offset = PER_W'(share / 6);
      default: offset = '0;
    endcase
  end

  assign prod = (PER_W+BRT_W)'(brt) * (PER_W+BRT_W)'(period);
  assign wrap = tick && (cnt_r == period - 1'b1);

  // Period counter on 20 MHz ticks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= offset;
    end else if (wrap) begin
      cnt_r <= '0;
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // New duty and current only at a boundary so no pulse is cut short
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      duty_r <= '0;
      cur_act_r <= CUR_RST;
    end else if (wrap) begin
      duty_r <= prod[PER_W+BRT_W-1:BRT_W];
      cur_act_r <= cur;
    end
  end

  // Duty-cycle dimming
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= enable && (cnt_r < duty_r);
    end
  end

endmodule : lcpb_chan

// ==== rtl/lcpb_detect.sv ====
/*
  String configuration detector: waits a settle time after reset, then
  samples the string presence and ganging senses once and decides the
  configuration, phase count and per-channel phase slot.
  Assumes the sense inputs are stable and synchronous to clk_sys.
*/
`timescale 1ns/10ps
module lcpb_detect
  import lcpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Senses
  input wire logic [lcpb_pkg::NCH-1:0] string_present,
  input wire logic [1:0] gang_sense,
  // Results
  output logic done_r,
  output logic [2:0] conf_r,
  output logic [2:0] nphase_r,
  output logic [lcpb_pkg::NCH-1:0] chan_en_r,
  output logic [3*lcpb_pkg::NCH-1:0] slot_r
);
  import lcpb_pkg::*;

  logic [DET_CNT_W-1:0] settle_cnt_r;
  logic [2:0] conf_nxt;
  logic [2:0] nph_nxt;
  logic [NCH-1:0] en_nxt;
  logic [3*NCH-1:0] slot_nxt;

  // Settle counter; detection happens exactly once per power-up
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      settle_cnt_r <= '0;
    end else if (!done_r) begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
    end
  end

  // Classify the sensed pattern
  always_comb begin
    conf_nxt = CONF_SIX;
    nph_nxt = 3'd6;
    en_nxt = '1;
    for (int i = 0; i < NCH; i++) begin
      slot_nxt[3*i +: 3] = 3'(i);
    end
    if (gang_sense == GANG_PAIRS) begin
      conf_nxt = CONF_GANG3;
      nph_nxt = 3'd3;
      for (int i = 0; i < NCH; i++) slot_nxt[3*i +: 3] = 3'(i / 2);
    end else if (gang_sense == GANG_TRIPLES) begin
      conf_nxt = CONF_GANG2;
      nph_nxt = 3'd2;
      for (int i = 0; i < NCH; i++) slot_nxt[3*i +: 3] = 3'(i / 3);
    end else if (gang_sense == GANG_ALL) begin
      conf_nxt = CONF_GANG1;
      nph_nxt = 3'd1;
      slot_nxt = '0;
    end else if (string_present == 6'h1F) begin
      conf_nxt = CONF_FIVE;
      nph_nxt = 3'd5;
      en_nxt = 6'h1F;
    end else if (string_present == 6'h0F) begin
      conf_nxt = CONF_FOUR;
      nph_nxt = 3'd4;
      en_nxt = 6'h0F;
    end else if (string_present == 6'h07) begin
      conf_nxt = CONF_THREE;
      nph_nxt = 3'd3;
      en_nxt = 6'h07;
    end else if (string_present == 6'h03) begin
      conf_nxt = CONF_TWO;
      nph_nxt = 3'd2;
      en_nxt = 6'h03;
    end
    // Any other pattern keeps six channels at 60 degrees
  end

  // Capture once when the settle time expires
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_r <= 1'b0;
      conf_r <= CONF_SIX;
      nphase_r <= 3'd6;
      chan_en_r <= '0;
      slot_r <= '0;
    end else if (!done_r && settle_cnt_r == DET_CNT_W'(DET_SETTLE_CYC - 1)) begin
      done_r <= 1'b1;
      conf_r <= conf_nxt;
      nphase_r <= nph_nxt;
      chan_en_r <= en_nxt;
      slot_r <= slot_nxt;
    end
  end

endmodule : lcpb_detect

// ==== rtl/lcpb_pkg.sv ====
/*
  Shared constants for the LED channel PWM brightness router: timing figures,
  register indices, field positions, reset values, source codes and the
  string configuration codes.
  Assumes a 40 MHz system clock; the 20 MHz PWM timebase is derived from it.
*/
package lcpb_pkg;

  // Clock and PWM timebase
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_HZ = 20_000_000;
  localparam int TICK_DIV = CLK_HZ / OSC_HZ;
  localparam int NCH = 6;
  localparam int PER_W = 18;
  localparam int BRT_W = 16;
  localparam int CUR_W = 12;
  localparam int SEL_W = 3;

  // Eight selectable PWM frequencies in Hz, selected by the resistor code
  localparam int FREQ_HZ [8] = '{152, 305, 610, 1221, 2441, 4883, 9766, 19531};

  // Detection settle time after reset, and its cycle count
  localparam int DET_SETTLE_US = 10;
  localparam int DET_SETTLE_CYC = DET_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int DET_CNT_W = 12;

  // Input PWM measurement window width in bits (65536 system clocks)
  localparam int MEAS_W = 16;

  // Register indices on the write/read port
  localparam logic [3:0] REG_CUR = 4'h0;
  localparam logic [3:0] REG_SRC = 4'h1;
  localparam logic [3:0] REG_CLUSTER = 4'h2;
  localparam logic [3:0] REG_EXT_SUPPLY = 4'h3;
  localparam logic [3:0] REG_DISPLAY_BRIGHTNESS_VALUE = 4'h4;
  localparam logic [3:0] REG_DISP_CTRL = 4'h5;
  localparam logic [3:0] REG_LOAD = 4'h6;
  localparam logic [3:0] REG_STRING_CONF = 4'h7;

  // Display control fields
  localparam int CTRL_INSEL_BIT = 0;
  localparam int CTRL_SLOPER_BIT = 1;
  localparam int CTRL_HYBRID_BIT = 2;

  // Reset values
  localparam logic [CUR_W-1:0] CUR_RST = 12'hFFF;
  localparam logic [SEL_W-1:0] SRC_RST = 3'h0;
  localparam logic [5:0] EXT_RST = 6'h00;
  localparam logic [BRT_W-1:0] BRT_RST = 16'h0000;

  // Brightness source codes
  localparam logic [SEL_W-1:0] SRC_DISPLAY = 3'h0;
  localparam logic [SEL_W-1:0] SRC_CLUSTER_LAST = 3'h5;

  // Ganging sense codes
  localparam logic [1:0] GANG_NONE = 2'h0;
  localparam logic [1:0] GANG_PAIRS = 2'h1;
  localparam logic [1:0] GANG_TRIPLES = 2'h2;
  localparam logic [1:0] GANG_ALL = 2'h3;

  // Detected string configuration codes
  localparam logic [2:0] CONF_SIX = 3'h0;
  localparam logic [2:0] CONF_FIVE = 3'h1;
  localparam logic [2:0] CONF_FOUR = 3'h2;
  localparam logic [2:0] CONF_THREE = 3'h3;
  localparam logic [2:0] CONF_TWO = 3'h4;
  localparam logic [2:0] CONF_GANG3 = 3'h5;
  localparam logic [2:0] CONF_GANG2 = 3'h6;
  localparam logic [2:0] CONF_GANG1 = 3'h7;

  // Period in 20 MHz ticks for a frequency code
  function automatic logic [PER_W-1:0] lcpb_period(input logic [2:0] code);
    int p;
    p = OSC_HZ / FREQ_HZ[code];
    return p[PER_W-1:0];
  endfunction : lcpb_period

endpackage : lcpb_pkg

// ==== rtl/lcpb_router.sv ====
/*
  LED channel PWM brightness router top: register set on a simple indexed
  write/read port, display path input selection, latched current and
  cluster updates, string detection and six phase-shifted PWM channels.
  Assumes the serial interface logic outside drives the register port
  synchronously to clk_sys, and the senses are stable after power-up.
*/
// Function
// - Per-channel 12-bit current code, resets full scale
// - Current codes take effect only on load trigger
// - PWM timebase from 20 MHz, unsynced to input
// - Eight resistor-selected PWM frequencies, 152 Hz-19.531 kHz
// - Duty resolution 16 down to 10 bits
// - Power-on string count detection sets even phases
// - Ganged groups of two, three, six supported
// - Unsupported pattern falls back to six, 60 degrees
// - Detected configuration readable as 3-bit field
// - Six 16-bit cluster brightness registers
// - 3-bit source selector per channel, reset display
// - External-supply mask removes channels from boost loop
// - Brightness by per-channel PWM duty at 20 MHz
// - One display path, five cluster paths
// - Display input from pin duty or register
// - Sloper on, hybrid off after reset
// - All channels follow display path after reset
`timescale 1ns/10ps
module lcpb_router
  import lcpb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic reg_wr,
  input wire logic [3:0] reg_idx,
  input wire logic [2:0] reg_ch,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata_r,
  // Power-up senses
  input wire logic [2:0] pwm_frequency_resistor,
  input wire logic [lcpb_pkg::NCH-1:0] string_present,
  input wire logic [1:0] gang_sense,
  // Input PWM pin
  input wire logic pwm_in,
  // Channel outputs
  output logic [lcpb_pkg::NCH-1:0] led_pwm_r,
  output logic [lcpb_pkg::NCH*lcpb_pkg::CUR_W-1:0] led_current_r,
  output logic [lcpb_pkg::NCH-1:0] boost_loop_en_r,
  // Display path controls and status
  output logic sloper_en_r,
  output logic hybrid_en_r,
  output logic [2:0] string_config_detected_r,
  output logic detect_done_r
);
  import lcpb_pkg::*;

  // Register storage
  logic [CUR_W-1:0] cur_wr_r [NCH];
  logic [CUR_W-1:0] cur_stage_r [NCH];
  logic [SEL_W-1:0] src_sel_r [NCH];
  logic [BRT_W-1:0] cluster_wr_r [NCH];
  logic [BRT_W-1:0] cluster_act_r [NCH];
  logic [NCH-1:0] ext_mask_r;
  logic [BRT_W-1:0] display_brightness_value_r;
  logic disp_insel_r;
  logic [PER_W-1:0] period_r;

  // Timebase and detection
  logic tick_r;
  logic started_r;
  logic start;
  logic det_done;
  logic [2:0] det_conf;
  logic [2:0] det_nphase;
  logic [NCH-1:0] det_en;
  logic [3*NCH-1:0] det_slot;

  // Input duty measurement
  logic [MEAS_W-1:0] win_cnt_r;
  logic [MEAS_W:0] high_cnt_r;
  logic [BRT_W-1:0] pin_duty_r;
  logic [BRT_W-1:0] disp_path;
  logic [BRT_W-1:0] chan_brt [NCH];
  logic [NCH-1:0] pwm_w;
  logic [CUR_W-1:0] cur_act [NCH];

  // Register writes; the load trigger copies staged values together
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        cur_wr_r[i] <= CUR_RST;
        cur_stage_r[i] <= CUR_RST;
        src_sel_r[i] <= SRC_RST;
        cluster_wr_r[i] <= BRT_RST;
        cluster_act_r[i] <= BRT_RST;
      end
      ext_mask_r <= EXT_RST;
      display_brightness_value_r <= BRT_RST;
      disp_insel_r <= 1'b0;
      sloper_en_r <= 1'b1;
      hybrid_en_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_idx == REG_CUR && reg_ch < 3'(NCH)) begin
        cur_wr_r[reg_ch] <= reg_wdata[CUR_W-1:0];
      end else if (reg_idx == REG_SRC && reg_ch < 3'(NCH)) begin
        src_sel_r[reg_ch] <= reg_wdata[SEL_W-1:0];
      end else if (reg_idx == REG_CLUSTER && reg_ch < 3'(NCH)) begin
        cluster_wr_r[reg_ch] <= reg_wdata;
      end else if (reg_idx == REG_EXT_SUPPLY) begin
        ext_mask_r <= reg_wdata[NCH-1:0];
      end else if (reg_idx == REG_DISPLAY_BRIGHTNESS_VALUE) begin
        display_brightness_value_r <= reg_wdata;
      end else if (reg_idx == REG_DISP_CTRL) begin
        disp_insel_r <= reg_wdata[CTRL_INSEL_BIT];
        sloper_en_r <= reg_wdata[CTRL_SLOPER_BIT];
        hybrid_en_r <= reg_wdata[CTRL_HYBRID_BIT];
      end else if (reg_idx == REG_LOAD) begin
        for (int i = 0; i < NCH; i++) begin
          cur_stage_r[i] <= cur_wr_r[i];
          cluster_act_r[i] <= cluster_wr_r[i];
        end
      end
    end
  end

  // Readback of stored values and block state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r <= '0;
    end else if (reg_idx == REG_CUR && reg_ch < 3'(NCH)) begin
      reg_rdata_r <= 16'(cur_wr_r[reg_ch]);
    end else if (reg_idx == REG_SRC && reg_ch < 3'(NCH)) begin
      reg_rdata_r <= 16'(src_sel_r[reg_ch]);
    end else if (reg_idx == REG_CLUSTER && reg_ch < 3'(NCH)) begin
      reg_rdata_r <= cluster_wr_r[reg_ch];
    end else if (reg_idx == REG_EXT_SUPPLY) begin
      reg_rdata_r <= 16'(ext_mask_r);
    end else if (reg_idx == REG_DISPLAY_BRIGHTNESS_VALUE) begin
      reg_rdata_r <= display_brightness_value_r;
    end else if (reg_idx == REG_DISP_CTRL) begin
      reg_rdata_r <= 16'({hybrid_en_r, sloper_en_r, disp_insel_r});
    end else if (reg_idx == REG_STRING_CONF) begin
      reg_rdata_r <= 16'(det_conf);
    end else begin
      reg_rdata_r <= '0;
    end
  end

  // 20 MHz tick from the 40 MHz clock; free-running, never tied to pwm_in
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
    end
  end

  // Frequency code followed until detection, then frozen with the senses.
  // Loaded ahead of start so the phase offsets see a valid period then.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      period_r <= '0;
      started_r <= 1'b0;
    end else if (!started_r) begin
      period_r <= lcpb_period(pwm_frequency_resistor);
      started_r <= det_done;
    end
  end

  assign start = det_done && !started_r;

  // Input duty averaged over a fixed window; coarse but needs no divider
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      win_cnt_r <= '0;
      high_cnt_r <= '0;
      pin_duty_r <= '0;
    end else begin
      win_cnt_r <= win_cnt_r + 1'b1;
      if (&win_cnt_r) begin
        pin_duty_r <= high_cnt_r[MEAS_W] ? '1 : high_cnt_r[BRT_W-1:0];
        high_cnt_r <= (MEAS_W+1)'(pwm_in);
      end else begin
        high_cnt_r <= high_cnt_r + (MEAS_W+1)'(pwm_in);
      end
    end
  end

  // Display path source, then per-channel routing
  assign disp_path = disp_insel_r ? pin_duty_r : display_brightness_value_r;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (src_sel_r[i] == SRC_DISPLAY) begin
        chan_brt[i] = disp_path;
      end else if (src_sel_r[i] <= SRC_CLUSTER_LAST) begin
        chan_brt[i] = cluster_act_r[src_sel_r[i]];
      end else begin
        chan_brt[i] = '0;
      end
    end
  end

  lcpb_detect u_detect (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .string_present(string_present),
    .gang_sense(gang_sense),
    .done_r(det_done),
    .conf_r(det_conf),
    .nphase_r(det_nphase),
    .chan_en_r(det_en),
    .slot_r(det_slot)
  );

  // One generator per channel
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    lcpb_chan u_chan (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .tick(tick_r),
      .start(start),
      .enable(started_r && det_en[g]),
      .period(period_r),
      .slot(det_slot[3*g +: 3]),
      .nphase(det_nphase),
      .brt(chan_brt[g]),
      .cur(cur_stage_r[g]),
      .pwm_r(pwm_w[g]),
      .cur_act_r(cur_act[g])
    );
  end

  // Output stage: every top output leaves from a flop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      led_pwm_r <= '0;
      led_current_r <= '0;
      boost_loop_en_r <= '0;
      string_config_detected_r <= CONF_SIX;
      detect_done_r <= 1'b0;
    end else begin
      led_pwm_r <= pwm_w;
      for (int i = 0; i < NCH; i++) begin
        led_current_r[CUR_W*i +: CUR_W] <= cur_act[i];
      end
      boost_loop_en_r <= det_en & ~ext_mask_r;
      string_config_detected_r <= det_conf;
      detect_done_r <= det_done;
    end
  end

endmodule : lcpb_router
